// file: rtl/mcr_pkg.sv
// Package: constants for the magstripe card reader input block
package mcr_pkg;
  // ----------------------------------------------------------------
  // Frame limits and codes
  // ----------------------------------------------------------------
  localparam int unsigned TRK2_MAX_CHARS = 40;
  localparam int unsigned ALNUM_MAX_CHARS = 79;
  localparam logic [5:0] ALNUM_START_SENT = 6'h05;
  localparam logic [5:0] ALNUM_END_SENT = 6'h0F;
  localparam logic [3:0] TRK2_START_SENT = 4'hB;
  localparam logic [3:0] TRK2_END_SENT = 4'hF;
  localparam int unsigned TRK2_DATA_BITS = 4;
  localparam int unsigned ALNUM_DATA_BITS = 6;
  // ----------------------------------------------------------------
  // Timing, buffer depth and field widths
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TRK2_MAX_BPS = 33336;
  localparam int unsigned ALNUM_MAX_BPS = 28984;
  localparam int unsigned TIMEOUT_MIN_NS = 60000;
  localparam int unsigned TIMEOUT_MIN_CYC = (TIMEOUT_MIN_NS + 24) / 25;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned STAT_W = 3;
  localparam int unsigned CNT_W = 7;
  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int unsigned ST_PARITY = 0;
  localparam int unsigned ST_LRC = 1;
  localparam int unsigned ST_ABORT = 2;
endpackage

// file: rtl/mcr_fifo.sv
// Generic flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module mcr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic push;
  logic pop;

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  assign in_ready = (cnt != (AW + 1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (cnt != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rp];

  // Storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + AW'(1);
      end
      if (pop) begin
        rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + AW'(1);
      end
      cnt <= cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

// file: rtl/mcr_reader.sv
// Magstripe card reader input: link capture, character checks, output stream
`timescale 1ns/1ps
module mcr_reader #(
  parameter int unsigned DEPTH = mcr_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic strobe_clk,
  input wire logic card_data_input_pin,
  input wire logic timeout_pin,
  input wire logic start,
  input wire logic alnum_track_reader_mode,
  input wire logic timeout_en,
  output logic busy,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic done,
  output logic [mcr_pkg::CNT_W-1:0] byte_count,
  output logic [mcr_pkg::STAT_W-1:0] status
);
  // ----------------------------------------------------------------
  // Link domain: capture each bit at the strobe falling edge
  // ----------------------------------------------------------------
  // Data is stable through the low phase, so the falling edge is safe
  // Toggle starts known so the first strobe edge already counts as a bit
  logic bit_val;
  logic bit_tog = 1'b0;
  always_ff @(negedge strobe_clk) begin
    bit_val <= card_data_input_pin;
    bit_tog <= ~bit_tog;
  end
  // Strobe may be idle at power-up; no bit event is taken before its first edge
  logic bit_init = 1'b0;
  always_ff @(negedge strobe_clk) begin
    bit_init <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Crossing into the core clock
  // ----------------------------------------------------------------
  logic tog_s1, tog_s2, tog_s3;
  logic val_s1, val_s2;
  logic ini_s1, ini_s2;
  logic to_s1, to_s2;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
      val_s1 <= 1'b0;
      val_s2 <= 1'b0;
      ini_s1 <= 1'b0;
      ini_s2 <= 1'b0;
      to_s1 <= 1'b0;
      to_s2 <= 1'b0;
    end else begin
      tog_s1 <= bit_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      val_s1 <= bit_val;
      val_s2 <= val_s1;
      ini_s1 <= bit_init;
      ini_s2 <= ini_s1;
      to_s1 <= timeout_pin;
      to_s2 <= to_s1;
    end
  end
  // Bit value settles long before toggle crosses: bit period far exceeds sync delay
  // One bit per toggle keeps pace with either reader rate at this clock
  logic bit_evt;
  assign bit_evt = ini_s2 && (tog_s2 != tog_s3);

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MCR_IDLE = 4'h1,
    MCR_HUNT = 4'h2,
    MCR_DATA = 4'h4,
    MCR_LRC = 4'h8
  } mcr_state_e;
  mcr_state_e state;
  mcr_state_e next_state;

  logic mode;
  logic [6:0] shreg;
  logic [2:0] nbits;
  logic [mcr_pkg::CNT_W-1:0] nchar;
  logic [5:0] lrc;
  logic perr;
  logic abort;
  logic fifo_in_ready;
  logic [6:0] next_shreg;
  logic [2:0] width;
  logic [5:0] chr;
  logic chr_par;
  logic sent_hit;
  logic end_hit;
  logic [mcr_pkg::CNT_W-1:0] max_chars;

  // Character width: data bits plus one parity bit
  assign width = mode ? 3'(mcr_pkg::ALNUM_DATA_BITS + 1) : 3'(mcr_pkg::TRK2_DATA_BITS + 1);
  assign max_chars = mode ? mcr_pkg::CNT_W'(mcr_pkg::ALNUM_MAX_CHARS)
                          : mcr_pkg::CNT_W'(mcr_pkg::TRK2_MAX_CHARS);
  // New bit enters at the top; character assembled LSB first
  assign next_shreg = mode ? {bit_val_core(), shreg[6:1]} : {2'b00, bit_val_core(), shreg[4:1]};

  function automatic logic bit_val_core();
    return val_s2;
  endfunction

  // Right-justify the assembled character and its parity bit
  always_comb begin
    chr = '0;
    chr_par = 1'b0;
    if (mode) begin
      chr = next_shreg[5:0];
      chr_par = next_shreg[6];
    end else begin
      chr = {2'b00, next_shreg[3:0]};
      chr_par = next_shreg[4];
    end
  end
  // Track 2 uses odd parity, alphanumeric even parity
  logic par_bad;
  assign par_bad = mode ? ((^chr) ^ chr_par) : ~((^chr) ^ chr_par);
  assign sent_hit = mode ? (chr == mcr_pkg::ALNUM_START_SENT)
                         : (chr[3:0] == mcr_pkg::TRK2_START_SENT);
  assign end_hit = mode ? (chr == mcr_pkg::ALNUM_END_SENT)
                        : (chr[3:0] == mcr_pkg::TRK2_END_SENT);

  logic char_done;
  assign char_done = bit_evt && (nbits == width) && (state != MCR_IDLE);
  // A character without room downstream is lost; 16 words covers any sane drain rate
  logic store;
  assign store = char_done && (state != MCR_HUNT || sent_hit) && par_ok_store();
  function automatic logic par_ok_store();
    return 1'b1;
  endfunction
  logic abort_now;
  assign abort_now = timeout_en && to_s2 && (state != MCR_IDLE);

  // State transitions; no internal timeout while waiting for strobes
  always_comb begin
    next_state = state;
    unique case (state)
      MCR_IDLE: if (start) next_state = MCR_HUNT;
      MCR_HUNT: if (char_done && sent_hit) next_state = MCR_DATA;
      MCR_DATA: begin
        if (char_done && (end_hit ||
            nchar + mcr_pkg::CNT_W'(1) >= max_chars - mcr_pkg::CNT_W'(1))) begin
          next_state = MCR_LRC;
        end
      end
      MCR_LRC: if (char_done) next_state = MCR_IDLE;
      default: next_state = MCR_IDLE;
    endcase
    if (abort_now) begin
      next_state = MCR_IDLE;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= MCR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Mode latched at start so a mid-read change is harmless
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode <= 1'b0;
    end else if (state == MCR_IDLE && start) begin
      mode <= alnum_track_reader_mode;
    end
  end

  // Bit shifter; in hunt a sliding window finds the sentinel on any bit
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shreg <= '0;
      nbits <= '0;
    end else if (state == MCR_IDLE) begin
      shreg <= '0;
      nbits <= 3'(1);
    end else if (bit_evt) begin
      shreg <= next_shreg;
      if (state == MCR_HUNT && !sent_hit) begin
        nbits <= width;
      end else if (nbits == width) begin
        nbits <= 3'(1);
      end else begin
        nbits <= nbits + 3'(1);
      end
    end
  end

  // Character count, LRC and error flags
  always_ff @(posedge clk) begin
    if (!rstn) begin
      nchar <= '0;
      lrc <= '0;
      perr <= 1'b0;
      abort <= 1'b0;
    end else if (state == MCR_IDLE && start) begin
      nchar <= '0;
      lrc <= '0;
      perr <= 1'b0;
      abort <= 1'b0;
    end else begin
      if (store) begin
        nchar <= nchar + mcr_pkg::CNT_W'(1);
        lrc <= lrc ^ chr;
        if (par_bad) perr <= 1'b1;
      end
      if (abort_now) abort <= 1'b1;
    end
  end

  // Completion report: flags and count held until the next read ends
  logic fin;
  assign fin = (state == MCR_LRC && char_done) || abort_now;
  logic [5:0] lrc_fin;
  assign lrc_fin = lrc ^ chr;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      done <= 1'b0;
      byte_count <= '0;
      status <= '0;
    end else begin
      done <= fin;
      if (fin) begin
        byte_count <= abort_now ? nchar : nchar + mcr_pkg::CNT_W'(1);
        status[mcr_pkg::ST_PARITY] <= perr || (!abort_now && par_bad);
        status[mcr_pkg::ST_LRC] <= !abort_now && (lrc_fin != 6'h00);
        status[mcr_pkg::ST_ABORT] <= abort_now;
      end
    end
  end
  assign busy = (state != MCR_IDLE);

  // ----------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------
  mcr_fifo #(
    .WIDTH(8),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_data({2'b00, chr}),
    .in_valid(store),
    .in_ready(fifo_in_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ABORT_IDLE: assert property (@(posedge clk) disable iff (!rstn)
    abort_now |=> state == MCR_IDLE && status[mcr_pkg::ST_ABORT])
    else $error("abort did not end the read");
  AST_MAX_CHARS: assert property (@(posedge clk) disable iff (!rstn)
    nchar <= max_chars)
    else $error("character count beyond limit");
  AST_IDLE_NO_STORE: assert property (@(posedge clk) disable iff (!rstn)
    state == MCR_IDLE |-> !store)
    else $error("store while idle");
  AST_HUNT_SENT: assert property (@(posedge clk) disable iff (!rstn)
    state == MCR_HUNT && store |-> sent_hit)
    else $error("stored before start sentinel");
  AST_DONE_PULSE: assert property (@(posedge clk) disable iff (!rstn)
    done |=> !done)
    else $error("done longer than one cycle");
  AST_BYTE_RJ: assert property (@(posedge clk) disable iff (!rstn)
    store |-> chr[5:4] == 2'b00 || mode)
    else $error("track 2 byte not right-justified");
  AST_SYNC: assert property (@(posedge clk) disable iff (!rstn)
    bit_evt |-> ini_s2 && $past(tog_s1) != $past(tog_s2))
    else $error("event without synchronised toggle");
  AST_BUSY_START: assert property (@(posedge clk) disable iff (!rstn)
    state == MCR_IDLE && start |=> busy)
    else $error("start not taken");
  COV_ALNUM: cover property (@(posedge clk) disable iff (!rstn) done && mode);
  COV_TRK2: cover property (@(posedge clk) disable iff (!rstn) done && !mode);
  COV_ABORT: cover property (@(posedge clk) disable iff (!rstn) abort_now);
endmodule

// file: sim/mcr_card_model.sv
// Behavioural card reader that drives strobe and data into the reader block
`timescale 1ns/1ps
module mcr_card_model (
  output logic strobe_clk,
  output logic card_data_input_pin
);
  // Strobe idles high and stands still between bursts
  initial begin
    strobe_clk = 1'b1;
    card_data_input_pin = 1'b1;
  end

  // Shift n bits out LSB first, one 6 ns low strobe pulse every 102 ns
  task automatic send_bits(input logic [15:0] v, input int n);
    int i;
    #0.7; // Keeps the strobe off the core clock phase
    for (i = 0; i < n; i++) begin
      card_data_input_pin = v[i];
      #6 strobe_clk = 1'b0;
      #6 strobe_clk = 1'b1;
      #90; // Gap between bits so each one crosses into the core clock
    end
    // Hold has run out and there is no pull-up, so the line flips
    card_data_input_pin = ~card_data_input_pin;
  endtask
endmodule

// file: sim/mcr_reader_tb.sv
// Self-checking bench for the magstripe card reader input block
`timescale 1ns/1ps
module mcr_reader_tb;
  logic clk, rstn, strobe_clk, card_data_input_pin, timeout_pin, start;
  logic alnum_track_reader_mode, timeout_en, busy, rx_valid, rx_ready, done;
  logic [7:0] rx_data;
  logic [mcr_pkg::CNT_W-1:0] byte_count;
  logic [mcr_pkg::STAT_W-1:0] status;
  logic [7:0] got[$];
  logic [7:0] exp_q[$];
  int done_n = 0;
  int bad_count = 0;
  int n_compared = 0;

  mcr_reader #(.DEPTH(mcr_pkg::FIFO_DEPTH)) i_dut (
    .clk(clk), .rstn(rstn), .strobe_clk(strobe_clk),
    .card_data_input_pin(card_data_input_pin), .timeout_pin(timeout_pin),
    .start(start), .alnum_track_reader_mode(alnum_track_reader_mode),
    .timeout_en(timeout_en), .busy(busy), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .done(done), .byte_count(byte_count), .status(status));
  mcr_card_model i_card (.strobe_clk(strobe_clk), .card_data_input_pin(card_data_input_pin));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Collect accepted bytes and count done pulses, which last one cycle only
  always @(posedge clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) got.push_back(rx_data);
    if (done === 1'b1) done_n++;
  end

  // ----------------------------------------------------------------
  // Compare and closing tasks
  // ----------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_stat(input logic [2:0] e, input logic [2:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic close_out();
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus helpers
  // ----------------------------------------------------------------
  // One character with its parity bit; a gap lets it cross into the core
  task automatic send_ch(input bit alnum, input logic [7:0] c, input bit flip);
    if (alnum) i_card.send_bits({9'h000, (^c[5:0]) ^ flip, c[5:0]}, 7);
    else i_card.send_bits({11'h000, (~^c[3:0]) ^ flip, c[3:0]}, 5);
    repeat (8) @(posedge clk);
  endtask

  // Full read: lead-in, characters, then LRC or an abort pulse
  task automatic run_read(input bit alnum, input logic [7:0] ch[$], input int bad_par,
                          input bit bad_lrc, input bit stall, input bit abort,
                          input logic [2:0] exp_st);
    logic [7:0] lrc;
    int i, n, d0, w;
    lrc = 8'h00;
    got.delete();
    exp_q.delete();
    d0 = done_n;
    @(posedge clk);
    #1;
    alnum_track_reader_mode = alnum;
    rx_ready = !stall;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    i_card.send_bits(16'h0000, 15);
    for (i = 0; i < ch.size(); i++) begin
      send_ch(alnum, ch[i], i == bad_par);
      lrc = lrc ^ ch[i];
      exp_q.push_back(ch[i]);
    end
    if (abort) begin
      @(posedge clk);
      #1 timeout_pin = 1'b1;
      repeat (4) @(posedge clk);
      #1 timeout_pin = 1'b0;
    end else begin
      send_ch(alnum, lrc ^ {7'h00, bad_lrc}, 1'b0);
      exp_q.push_back(lrc ^ {7'h00, bad_lrc});
    end
    w = 0;
    while (done_n == d0 && w < 400) begin
      @(posedge clk);
      w++;
    end
    chk_byte(8'h01, 8'(done_n - d0));
    #1 rx_ready = 1'b1;
    repeat (40) @(posedge clk);
    n = stall ? mcr_pkg::FIFO_DEPTH : exp_q.size();
    chk_byte(8'(n), 8'(got.size()));
    chk_byte(8'h01, 8'(got.size() <= 78));
    for (i = 0; i < n && i < got.size(); i++) chk_byte(exp_q[i], got[i]);
    if (!stall) chk_byte(8'(n), {1'b0, byte_count});
    chk_stat(exp_st, status);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_alnum_ok();
    run_read(1'b1, '{8'h05, 8'h21, 8'h3A, 8'h10, 8'h0F}, -1, 1'b0, 1'b0, 1'b0,
             3'b000);
  endtask

  task automatic t_alnum_parity();
    run_read(1'b1, '{8'h05, 8'h2C, 8'h13, 8'h0F}, 2, 1'b0, 1'b0, 1'b0, 3'b001);
  endtask

  task automatic t_trk2_lrc();
    run_read(1'b0, '{8'h0B, 8'h03, 8'h07, 8'h00, 8'h0F}, -1, 1'b1, 1'b0, 1'b0,
             3'b010);
  endtask

  task automatic t_abort();
    run_read(1'b1, '{8'h05, 8'h11, 8'h22}, -1, 1'b0, 1'b0, 1'b1, 3'b100);
  endtask

  // Far side stalls so the 16-word buffer fills and refuses the rest
  task automatic t_fifo_full();
    logic [7:0] q[$];
    int i;
    q.push_back(8'h05);
    for (i = 0; i < 18; i++) q.push_back(8'(i + 8'h10));
    q.push_back(8'h0F);
    run_read(1'b1, q, -1, 1'b0, 1'b1, 1'b0, 3'b000);
  endtask

  initial begin
    rstn = 1'b0;
    timeout_pin = 1'b0;
    start = 1'b0;
    alnum_track_reader_mode = 1'b0;
    timeout_en = 1'b1;
    rx_ready = 1'b1;
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
    t_alnum_ok();
    t_alnum_parity();
    t_trk2_lrc();
    t_abort();
    t_fifo_full();
    close_out();
  end

  // Reads take tens of microseconds; this cuts a hang short
  initial begin
    #500us;
    bad_count++;
    close_out();
  end
endmodule
